/* hw/node_state_event.sv */
// Purpose: Node functional state control and main event summary with its masks
// Assumes: Event inputs other than bus activity come from logic on clk
// Notes: Register reads answer one cycle later on rdata; reads clear alternate event and FIFO warning bits
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - State register reads/writes, resets to zero
// RULE2 - Selector lives in bits one to zero
// RULE3 - Code 00 is bus reset state
// RULE4 - Entering bus reset disables all endpoint pipes
// RULE5 - Software handles default-endpoint and address flags
// RULE6 - Code 01 drives resume K upstream
// RULE7 - Software holds resume 1 to 15 ms
// RULE8 - Code 10 is normal operation
// RULE9 - Software enters suspend after suspend event
// RULE10 - Suspend puts transceivers in low power
// RULE11 - Suspend resets endpoints, transfer bits; freezes rest
// RULE12 - Bus activity in suspend sets resume flag
// RULE13 - Software performs all state changes itself
// RULE14 - Eight-bit main event register, reset zero
// RULE15 - Main event register ignores writes
// RULE16 - Bit 0 follows unmasked FIFO warnings
// RULE17 - Bit 1 sets on unmasked alternate event
// RULE18 - Mask gates events; bit 7 master enable
module node_state_event
  import node_state_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cpu_req_t cpu_req,
  output logic [DATA_W-1:0] cpu_rdata,
  input wire logic bus_activity,
  input wire alt_in_t alt_in,
  input wire logic [DATA_W-1:0] fifo_warn_set,
  input wire summary_in_t summary_in,
  output node_ctl_t node_ctl,
  output logic usb_irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    node_state_selector_t sel;
    logic [DATA_W-1:0] main_mask;
    logic [DATA_W-1:0] alt_event;
    logic [DATA_W-1:0] alt_mask;
    logic [DATA_W-1:0] fifo_warn;
    logic [DATA_W-1:0] fifo_mask;
    logic alt_sum;
    logic act_s1;
    logic act_s2;
    logic pipes_disable;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [DATA_W-1:0] main_event;
  logic wr_state;
  logic [DATA_W-1:0] alt_new;

  // ==========================================================================
  // Main event summary, never stored so writes cannot touch it
  always_comb begin
    main_event = RST_BYTE; // RULE14 RULE15
    main_event[MEV_WARN] = |(s_q.fifo_warn & s_q.fifo_mask); // RULE16
    main_event[MEV_ALT] = s_q.alt_sum; // RULE17
    main_event[MEV_TX] = summary_in.tx_ev;
    main_event[MEV_FRAME] = summary_in.frame;
    main_event[MEV_NAK] = summary_in.nak;
    main_event[MEV_ULD] = summary_in.uld;
    main_event[MEV_RX] = summary_in.rx_ev;
  end

  assign wr_state = cpu_req.wr && (cpu_req.addr == OFS_NODE_STATE);

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.act_s1 = bus_activity;
    s_d.act_s2 = s_q.act_s1;
    s_d.pipes_disable = 1'b0;

    // Register writes; reserved selector bits are dropped
    if (wr_state) begin
      s_d.sel = node_state_selector_t'(cpu_req.wdata[SEL_W-1:0]); // RULE1 RULE2 RULE13
      if (node_state_selector_t'(cpu_req.wdata[SEL_W-1:0]) == BUS_RESET_STATE &&
          s_q.sel != BUS_RESET_STATE) begin
        s_d.pipes_disable = 1'b1; // RULE3 RULE4
      end
    end
    if (cpu_req.wr && cpu_req.addr == OFS_MAIN_MASK) begin
      s_d.main_mask = cpu_req.wdata;
    end
    if (cpu_req.wr && cpu_req.addr == OFS_ALT_MASK) begin
      s_d.alt_mask = cpu_req.wdata & AEV_IMPL;
    end
    if (cpu_req.wr && cpu_req.addr == OFS_FIFO_MASK) begin
      s_d.fifo_mask = cpu_req.wdata;
    end

    // Register reads; alternate event and FIFO warning bits clear on read
    if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        OFS_NODE_STATE: s_d.rdata = {{(DATA_W-SEL_W){1'b0}}, s_q.sel};
        OFS_MAIN_EVENT: s_d.rdata = main_event;
        OFS_MAIN_MASK: s_d.rdata = s_q.main_mask;
        OFS_ALT_EVENT: begin
          s_d.rdata = s_q.alt_event;
          s_d.alt_event = RST_BYTE;
          s_d.alt_sum = 1'b0; // RULE17
        end
        OFS_ALT_MASK: s_d.rdata = s_q.alt_mask;
        OFS_FIFO_WARN: begin
          s_d.rdata = s_q.fifo_warn;
          s_d.fifo_warn = RST_BYTE; // RULE16
        end
        OFS_FIFO_MASK: s_d.rdata = s_q.fifo_mask;
        default: s_d.rdata = RST_BYTE;
      endcase
    end

    // Hardware sets win over read clears
    alt_new = RST_BYTE;
    alt_new[AEV_DMA] = alt_in.dma;
    alt_new[AEV_EOP] = alt_in.eop;
    alt_new[AEV_SD3] = alt_in.sd3;
    alt_new[AEV_SD5] = alt_in.sd5;
    alt_new[AEV_RESET] = alt_in.usb_reset;
    alt_new[AEV_RESUME] = (s_q.sel == LOW_POWER_STATE) && s_q.act_s2; // RULE12
    // A bit cleared by this cycle's read and set again still counts as newly set
    if (|(alt_new & ~s_d.alt_event & s_q.alt_mask)) begin
      s_d.alt_sum = 1'b1; // RULE17
    end
    s_d.alt_event = s_d.alt_event | alt_new;
    s_d.fifo_warn = s_d.fifo_warn | fifo_warn_set; // RULE16
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.sel <= BUS_RESET_STATE; // RULE1 RULE3
      s_q.main_mask <= RST_BYTE;
      s_q.alt_event <= RST_BYTE;
      s_q.alt_mask <= RST_BYTE;
      s_q.fifo_warn <= RST_BYTE;
      s_q.fifo_mask <= RST_BYTE;
      s_q.alt_sum <= 1'b0;
      s_q.act_s1 <= 1'b0;
      s_q.act_s2 <= 1'b0;
      s_q.pipes_disable <= 1'b1; // RULE4
      s_q.rdata <= RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // Pipes stay disabled through bus reset; the pulse marks the entry itself
  always_comb begin
    node_ctl.pipes_disable = s_q.pipes_disable || (s_q.sel == BUS_RESET_STATE); // RULE4
    node_ctl.resume_k_drive = (s_q.sel == REMOTE_WAKE_STATE); // RULE6
    node_ctl.xcvr_suspend = (s_q.sel == LOW_POWER_STATE); // RULE10
    node_ctl.ep_ctrl_reset = (s_q.sel == LOW_POWER_STATE); // RULE11
    node_ctl.xfer_bits_clear = (s_q.sel == LOW_POWER_STATE); // RULE11
    node_ctl.state_freeze = (s_q.sel == LOW_POWER_STATE); // RULE11
  end

  // Normal run state enables no extra side effect: all controls idle
  // RULE8 is satisfied by every control output being low in that code

  assign usb_irq = s_q.main_mask[MEV_MASTER] &&
                   |(main_event[MEV_MASTER-1:0] & s_q.main_mask[MEV_MASTER-1:0]); // RULE18
  assign cpu_rdata = s_q.rdata;

endmodule : node_state_event

`default_nettype wire

/* hw/node_state_pkg.sv */
// Purpose: Shared constants and types for the node state and event summary block
// Assumes: 8-bit CPU register bus, byte addressed by the low address byte
// Notes: Offsets are the low byte of the memory-mapped register addresses
package node_state_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_NODE_STATE = 8'h8a;
  localparam logic [ADDR_W-1:0] OFS_MAIN_EVENT = 8'h8c;
  localparam logic [ADDR_W-1:0] OFS_MAIN_MASK = 8'h8e;
  localparam logic [ADDR_W-1:0] OFS_ALT_EVENT = 8'h90;
  localparam logic [ADDR_W-1:0] OFS_ALT_MASK = 8'h92;
  localparam logic [ADDR_W-1:0] OFS_FIFO_WARN = 8'ha0;
  localparam logic [ADDR_W-1:0] OFS_FIFO_MASK = 8'ha2;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int unsigned SEL_W = 2;
  localparam int unsigned MEV_WARN = 0;
  localparam int unsigned MEV_ALT = 1;
  localparam int unsigned MEV_TX = 2;
  localparam int unsigned MEV_FRAME = 3;
  localparam int unsigned MEV_NAK = 4;
  localparam int unsigned MEV_ULD = 5;
  localparam int unsigned MEV_RX = 6;
  localparam int unsigned MEV_MASTER = 7;
  localparam int unsigned AEV_DMA = 2;
  localparam int unsigned AEV_EOP = 3;
  localparam int unsigned AEV_SD3 = 4;
  localparam int unsigned AEV_SD5 = 5;
  localparam int unsigned AEV_RESET = 6;
  localparam int unsigned AEV_RESUME = 7;
  localparam logic [DATA_W-1:0] AEV_IMPL = 8'hfc;

  // ==========================================================================
  // Node state selector codes
  typedef enum logic [SEL_W-1:0] {
    BUS_RESET_STATE = 2'h0,
    REMOTE_WAKE_STATE = 2'h1,
    NORMAL_RUN_STATE = 2'h2,
    LOW_POWER_STATE = 2'h3
  } node_state_selector_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic tx_ev;
    logic frame;
    logic nak;
    logic uld;
    logic rx_ev;
  } summary_in_t;

  typedef struct packed {
    logic eop;
    logic sd3;
    logic sd5;
    logic usb_reset;
    logic dma;
  } alt_in_t;

  typedef struct packed {
    logic pipes_disable;
    logic ep_ctrl_reset;
    logic xfer_bits_clear;
    logic xcvr_suspend;
    logic resume_k_drive;
    logic state_freeze;
  } node_ctl_t;

endpackage : node_state_pkg

/* test/node_state_event_asserts.sv */
// Purpose: node state checks. Assumes: one clock, sync reset. Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module node_state_event_asserts
  import node_state_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cpu_req_t cpu_req,
  input wire logic [DATA_W-1:0] cpu_rdata,
  input wire node_ctl_t node_ctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sel(logic [1:0] c);
    cpu_req.wr && cpu_req.addr == OFS_NODE_STATE && cpu_req.wdata[1:0] == c;
  endsequence
  a_rst_state: assert property (disable iff (1'b0) rst |=> node_ctl.pipes_disable)
    else $error("no bus reset");
  a_sel_upper: assert property (cpu_req.rd && cpu_req.addr == OFS_NODE_STATE |=>
    cpu_rdata[7:2] == 6'h00) else $error("upper bits set");
  a_main_bit7: assert property (cpu_req.rd && cpu_req.addr == OFS_MAIN_EVENT |=>
    !cpu_rdata[7]) else $error("bit 7 set");
  a_bus_reset: assert property (s_sel(2'h0) |=> node_ctl.pipes_disable)
    else $error("pipes live");
  a_wake_drive: assert property (s_sel(2'h1) |=> node_ctl.resume_k_drive)
    else $error("no resume K");
  a_normal_run: assert property (s_sel(2'h2) |=> !node_ctl.resume_k_drive
    && !node_ctl.xcvr_suspend) else $error("side effects");
  a_low_power: assert property (s_sel(2'h3) |=> node_ctl.xcvr_suspend
    && node_ctl.ep_ctrl_reset && node_ctl.xfer_bits_clear) else $error("no suspend");
  a_state_steady: assert property (!(cpu_req.wr && cpu_req.addr == OFS_NODE_STATE) |=>
    $stable(node_ctl.xcvr_suspend) && $stable(node_ctl.resume_k_drive)) else $error("moved");
endmodule : node_state_event_asserts
bind node_state_event node_state_event_asserts node_state_event_asserts_inst (.clk(clk),
  .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .node_ctl(node_ctl));
`default_nettype wire

/* test/upstream_model.sv */
// Purpose: upstream port stand-in. Assumes: activity is an async level. Notes: off clock phase
`timescale 1ns/1ps
`default_nettype none
module upstream_model (
  input wire logic resume_k,
  input wire logic wake_req,
  output logic bus_activity
);
  initial bus_activity = 1'b0;
  // Hub repeats resume K; a wake request is the host resuming
  always @(resume_k or wake_req) bus_activity <= #3.3 resume_k | wake_req;
endmodule : upstream_model
`default_nettype wire

/* test/node_state_event_tb.sv */
// Purpose: node state bench. Assumes: inputs move on falling edges. Notes: ends with a reset
`timescale 1ns/1ps
`default_nettype none
module node_state_event_tb
  import node_state_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wake_req = 1'b0, bus_activity, usb_irq;
  logic [7:0] warn = 8'h00, rdata;
  cpu_req_t req = '0;
  alt_in_t other_events_summary = '0;
  summary_in_t sum = '0;
  node_ctl_t ctl;
  int bad_count = 0, comparisons = 0;
  node_state_event node_state_event_inst (.clk(clk), .rst(rst), .cpu_req(req), .cpu_rdata(rdata),
    .bus_activity(bus_activity), .alt_in(other_events_summary), .fifo_warn_set(warn), .summary_in(sum),
    .node_ctl(ctl), .usb_irq(usb_irq));
  upstream_model upstream_model_inst (.resume_k(ctl.resume_k_drive), .wake_req(wake_req),
    .bus_activity(bus_activity));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) $display("MISMATCH %0t got %h want %h", $time, g, e);
    if (g !== e) bad_count++;
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    if (!w) chk(rdata, d);
  endtask : bus
  task automatic t_states;
    logic [1:0] c;
    logic [7:0] e;
    bus(1'b0, OFS_NODE_STATE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 2'(3 - i);
      e = {2'h0, c == 0, {3{c == 3}}, c == 1, c == 3};
      // Endpoint flags and wake hold time are software's; the bench keeps wake short
      bus(1'b1, OFS_NODE_STATE, {6'h3f, c});
      bus(1'b0, OFS_NODE_STATE, {6'h00, c});
      chk({2'h0, ctl}, e);
    end
  endtask : t_states
  task automatic t_events;
    bus(1'b1, OFS_MAIN_EVENT, 8'hff);
    bus(1'b1, OFS_FIFO_MASK, 8'h01);
    warn = 8'h03;
    other_events_summary = '1;
    @(negedge clk);
    warn = 8'h00;
    other_events_summary = '0;
    bus(1'b0, OFS_MAIN_EVENT, 8'h01);
    bus(1'b0, OFS_FIFO_WARN, 8'h03);
    bus(1'b0, OFS_MAIN_EVENT, 8'h00);
    sum = 5'b10100;
    bus(1'b0, OFS_MAIN_EVENT, 8'h14);
    sum = 5'b01011;
    bus(1'b0, OFS_MAIN_EVENT, 8'h68);
    sum = '0;
  endtask : t_events
  task automatic t_resume;
    bus(1'b1, OFS_ALT_MASK, 8'h80);
    bus(1'b1, OFS_MAIN_MASK, 8'h82);
    bus(1'b1, OFS_NODE_STATE, 8'h02);
    other_events_summary.sd3 = 1'b1;
    other_events_summary.usb_reset = 1'b1;
    @(negedge clk);
    other_events_summary = '0;
    bus(1'b0, OFS_NODE_STATE, 8'h02);
    bus(1'b1, OFS_NODE_STATE, 8'h03);
    wake_req = 1'b1;
    repeat (6) @(negedge clk);
    wake_req = 1'b0;
    chk({7'h00, usb_irq}, 8'h01);
    bus(1'b1, OFS_MAIN_MASK, 8'h02);
    chk({7'h00, usb_irq}, 8'h00);
    bus(1'b0, OFS_MAIN_EVENT, 8'h02);
    bus(1'b0, OFS_ALT_EVENT, 8'hfc);
    bus(1'b0, OFS_MAIN_EVENT, 8'h00);
  endtask : t_resume
  task automatic t_reset;
    bus(1'b1, OFS_MAIN_MASK, 8'h81);
    bus(1'b1, OFS_NODE_STATE, 8'h02);
    warn = 8'h01;
    @(negedge clk);
    warn = 8'h00;
    chk({7'h00, usb_irq}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({2'h0, ctl}, 8'h20);
    chk({7'h00, usb_irq}, 8'h00);
    bus(1'b0, OFS_NODE_STATE, 8'h00);
    bus(1'b0, OFS_MAIN_EVENT, 8'h00);
    bus(1'b0, OFS_MAIN_MASK, 8'h00);
  endtask : t_reset
  task automatic tally_and_finish;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000 bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_states;
    t_events;
    t_resume;
    t_reset;
    tally_and_finish;
  end
endmodule : node_state_event_tb
`default_nettype wire
